// [testbench.sv]
// testbench: self-checking bench for the vicx_core exit decision block.
// assumes the word map, control bits and one-cycle pulse protocol of vicx_pkg.
`timescale 1ns/1ps
module testbench;
  import vicx_pkg::*;
  logic i_clk, i_rst, i_wr, i_rd, i_acc_valid, i_tpr_wr, i_eoi_wr, i_msr_valid;
  logic i_fetch_valid, i_entry;
  logic [4:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [63:0] i_acc_addr, o_fetch_addr, o_vpage_addr, o_desc_addr, o_exec_ptr;
  logic [7:0] i_tpr_value, i_eoi_vec, i_fetch_data, o_notify_vec;
  vicx_msr_req_t i_msr_req;
  logic o_irq, o_acc_hit, o_tpr_exit, o_eoi_exit, o_msr_busy, o_msr_vpage, o_msr_done;
  logic o_msr_exit, o_fetch_req, o_entry_done, o_entry_fail;
  int err_count = 0;
  int checked = 0;

  vicx_core u_vicx_core (
    .I_CLK(i_clk), .I_RST(i_rst), .I_ADDR(i_addr), .I_WDATA(i_wdata), .I_WR(i_wr),
    .I_RD(i_rd), .O_RDATA(o_rdata), .O_IRQ(o_irq), .I_ACC_VALID(i_acc_valid),
    .I_ACC_ADDR(i_acc_addr), .O_ACC_HIT(o_acc_hit), .I_TPR_WR(i_tpr_wr),
    .I_TPR_VALUE(i_tpr_value), .O_TPR_EXIT(o_tpr_exit), .I_EOI_WR(i_eoi_wr),
    .I_EOI_VEC(i_eoi_vec), .O_EOI_EXIT(o_eoi_exit), .I_MSR_VALID(i_msr_valid),
    .I_MSR_REQ(i_msr_req), .O_MSR_BUSY(o_msr_busy), .O_MSR_VPAGE(o_msr_vpage),
    .O_MSR_DONE(o_msr_done), .O_MSR_EXIT(o_msr_exit), .O_FETCH_REQ(o_fetch_req),
    .O_FETCH_ADDR(o_fetch_addr), .I_FETCH_VALID(i_fetch_valid),
    .I_FETCH_DATA(i_fetch_data), .I_ENTRY(i_entry), .O_ENTRY_DONE(o_entry_done),
    .O_ENTRY_FAIL(o_entry_fail), .O_NOTIFY_VEC(o_notify_vec),
    .O_VPAGE_ADDR(o_vpage_addr), .O_DESC_ADDR(o_desc_addr), .O_EXEC_PTR(o_exec_ptr)
  );

  // 25 ns clock
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // one-cycle register write; strobe dropped at the taking edge
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // read data only stands the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  // sel bits: 0 access, 1 priority write, 2 end-of-interrupt, 3 entry
  task automatic pulse(input logic [3:0] sel, input logic [63:0] v);
    @(posedge i_clk);
    {i_entry, i_eoi_wr, i_tpr_wr, i_acc_valid} <= sel;
    i_acc_addr <= v;
    i_tpr_value <= v[7:0];
    i_eoi_vec <= v[7:0];
    @(posedge i_clk);
    {i_entry, i_eoi_wr, i_tpr_wr, i_acc_valid} <= 4'h0;
    #1;
  endtask : pulse

  task automatic msr(input logic w, input logic [31:0] idx);
    @(posedge i_clk);
    i_msr_valid <= 1'b1;
    i_msr_req <= {w, idx};
    @(posedge i_clk);
    i_msr_valid <= 1'b0;
    #1;
  endtask : msr

  task automatic t_regs();
    logic [31:0] d;
    rd(A_CTRL, d);
    chk(d, 32'h0);
    wr(5'h10, 32'h8765_4321);
    wr(5'h11, 32'hfedc_ba98);
    wr(5'h0c, 32'h1234_567f);
    wr(A_PNV, 32'h0000_abcd);
    wr(5'h17, 32'hffff_ffff);
    rd(5'h11, d);
    chk(d, 32'hfedc_ba98);
    chk(o_exec_ptr, 64'hfedc_ba98_8765_4321);
    chk(o_desc_addr, 64'h1234_5640);
    chk(o_notify_vec, 8'hcd);
    rd(A_PNV, d);
    chk(d, 32'h0000_abcd);
    rd(5'h17, d);
    chk(d, 32'h0);
  endtask : t_regs

  // upper threshold bits must not matter; equal nibble does not exit
  task automatic t_tpr();
    logic [31:0] d;
    wr(A_THR, 32'hffff_fff5);
    wr(A_MASK, 32'h1);
    wr(A_CTRL, 32'h4);
    pulse(4'h2, 64'h4f);
    chk(o_tpr_exit, 1'b1);
    repeat (2) @(posedge i_clk);
    #1 chk(o_irq, 1'b1);
    pulse(4'h2, 64'h50);
    chk(o_tpr_exit, 1'b0);
    wr(A_CTRL, 32'hc);
    pulse(4'h2, 64'h00);
    chk(o_tpr_exit, 1'b0);
    wr(A_STAT, 32'h1);
    rd(A_STAT, d);
    chk(d, 32'h0);
    #1 chk(o_irq, 1'b0);
  endtask : t_tpr

  task automatic t_eoi();
    logic [7:0] vec [5] = '{8'h41, 8'h40, 8'h61, 8'hff, 8'h01};
    logic ex [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [31:0] d;
    wr(5'h06, 32'h2);
    wr(5'h0b, 32'h8000_0000);
    for (int k = 0; k < 5; k++) begin
      pulse(4'h4, {56'h0, vec[k]});
      chk(o_eoi_exit, ex[k]);
    end
    #1 chk(o_irq, 1'b0);
    wr(A_MASK, 32'h2);
    rd(A_STAT, d);
    chk(d, 32'h2);
    chk(o_irq, 1'b1);
  endtask : t_eoi

  task automatic t_msr();
    logic [31:0] idx [4] = '{32'hc000_0009, 32'h0000_1fff, 32'hc000_0000, 32'h0};
    logic [63:0] adr [4] = '{64'h4_0401, 64'h4_0bff, 64'h4_0c00, 64'h4_0000};
    logic [7:0] dat [4] = '{8'h02, 8'h7f, 8'hfe, 8'h01};
    logic ex [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic [31:0] d;
    wr(5'h0e, 32'h0004_0000);
    msr(1'b0, 32'h10);
    chk({o_msr_done, o_msr_exit, o_fetch_req}, 3'b110);
    wr(A_CTRL, 32'h10);
    msr(1'b1, 32'h2000);
    chk({o_msr_done, o_msr_exit, o_fetch_req}, 3'b110);
    msr(1'b0, 32'hc000_2000);
    chk({o_msr_done, o_msr_exit, o_fetch_req}, 3'b110);
    for (int k = 0; k < 4; k++) begin
      msr(k == 1 || k == 2, idx[k]);
      chk({o_fetch_req, o_msr_busy, o_fetch_addr}, {2'b11, adr[k]});
      @(posedge i_clk);
      i_fetch_valid <= 1'b1;
      i_fetch_data <= dat[k];
      @(posedge i_clk);
      i_fetch_valid <= 1'b0;
      #1 chk({o_msr_done, o_msr_exit, o_msr_busy}, {1'b1, ex[k], 1'b0});
    end
    // x2 control alone: no lookup, so each request ends at once
    wr(A_CTRL, 32'h2);
    msr(1'b0, 32'h8ff);
    chk(o_msr_vpage, 1'b1);
    msr(1'b1, 32'h800);
    chk(o_msr_vpage, 1'b1);
    msr(1'b0, 32'h900);
    chk(o_msr_vpage, 1'b0);
    wr(A_CTRL, 32'h0);
    msr(1'b0, 32'h800);
    chk(o_msr_vpage, 1'b0);
    // exits above left the model-register status bit set beside the eoi bit
    rd(A_STAT, d);
    chk(d, 32'h6);
  endtask : t_msr

  task automatic t_entry_acc();
    wr(A_CTRL, 32'h5);
    wr(5'h02, 32'h0000_1010);
    pulse(4'h8, 64'h0);
    chk({o_entry_done, o_entry_fail}, 2'b11);
    wr(5'h02, 32'h0000_1000);
    pulse(4'h8, 64'h0);
    chk({o_entry_done, o_entry_fail}, 2'b10);
    chk(o_vpage_addr, 64'h1000);
    wr(5'h00, 32'h0000_3000);
    pulse(4'h1, 64'h3ffc);
    chk(o_acc_hit, 1'b1);
    pulse(4'h1, 64'h4000);
    chk(o_acc_hit, 1'b0);
    wr(A_CTRL, 32'h4);
    pulse(4'h1, 64'h3000);
    chk(o_acc_hit, 1'b0);
  endtask : t_entry_acc

  // watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #(25 * 5000);
    err_count++;
    print_verdict();
  end

  // reset for two cycles, then every scenario in turn
  initial begin
    {i_wr, i_rd, i_acc_valid, i_tpr_wr, i_eoi_wr, i_msr_valid, i_fetch_valid} = '0;
    {i_entry, i_addr, i_wdata, i_acc_addr, i_tpr_value, i_eoi_vec} = '0;
    {i_fetch_data, i_msr_req} = '0;
    i_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    t_tpr();
    t_eoi();
    t_msr();
    t_entry_acc();
    print_verdict();
  end
endmodule : testbench

// [vicx_core.sv]
// vicx_core: control fields and exit decisions for interrupt-controller
// and model-register virtualization.
// assumes one clock, synchronous inputs, a one-cycle-pulse request
// protocol and an outside memory port that returns bitmap bytes.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module vicx_core
  import vicx_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [VICX_AW-1:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  output logic O_IRQ,
  input wire logic I_ACC_VALID,
  input wire logic [63:0] I_ACC_ADDR,
  output logic O_ACC_HIT,
  input wire logic I_TPR_WR,
  input wire logic [VEC_W-1:0] I_TPR_VALUE,
  output logic O_TPR_EXIT,
  input wire logic I_EOI_WR,
  input wire logic [VEC_W-1:0] I_EOI_VEC,
  output logic O_EOI_EXIT,
  input wire logic I_MSR_VALID,
  input wire vicx_msr_req_t I_MSR_REQ,
  output logic O_MSR_BUSY,
  output logic O_MSR_VPAGE,
  output logic O_MSR_DONE,
  output logic O_MSR_EXIT,
  output logic O_FETCH_REQ,
  output logic [63:0] O_FETCH_ADDR,
  input wire logic I_FETCH_VALID,
  input wire logic [7:0] I_FETCH_DATA,
  input wire logic I_ENTRY,
  output logic O_ENTRY_DONE,
  output logic O_ENTRY_FAIL,
  output logic [VEC_W-1:0] O_NOTIFY_VEC,
  output logic [63:0] O_VPAGE_ADDR,
  output logic [63:0] O_DESC_ADDR,
  output logic [63:0] O_EXEC_PTR
);
  logic [63:0] fld [0:VICX_NUM_FLD-1];
  logic [THR_W-1:0] thr;
  logic [PNV_W-1:0] pnv;
  logic [CTL_W-1:0] ctrl;
  logic [EV_W-1:0] stat;
  logic [EV_W-1:0] mask;
  logic [EV_W-1:0] ev;
  logic [3:0] wsel;
  vicx_msr_st_t ms;
  logic [2:0] bit_pos;
  logic in_low;
  logic in_high;
  logic [3:0] eoi_sel;
  logic next_tpr_exit;
  logic next_eoi_exit;
  logic next_entry_fail;

  assign wsel = I_ADDR[4:1];

  // 64-bit fields written one 32-bit half at a time
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      for (int f = 0; f < VICX_NUM_FLD; f++) begin
        fld[f] <= 64'h0;
      end
    end else if (I_WR && I_ADDR < A_FLD_END) begin
      if (I_ADDR[0]) begin
        fld[wsel][63:32] <= I_WDATA;
      end else begin
        fld[wsel][31:0] <= I_WDATA;
      end
    end
  end

  // narrow fields and control bits
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      thr <= '0;
      pnv <= '0;
      ctrl <= '0;
      mask <= '0;
    end else if (I_WR) begin
      if (I_ADDR == A_THR) thr <= I_WDATA;
      if (I_ADDR == A_PNV) pnv <= I_WDATA[PNV_W-1:0];
      if (I_ADDR == A_CTRL) ctrl <= I_WDATA[CTL_W-1:0];
      if (I_ADDR == A_MASK) mask <= I_WDATA[EV_W-1:0];
    end
  end

  // sticky status, write one to clear; a same-cycle event wins
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      stat <= '0;
    end else if (I_WR && I_ADDR == A_STAT) begin
      stat <= (stat & ~I_WDATA[EV_W-1:0]) | ev;
    end else begin
      stat <= stat | ev;
    end
  end

  // read data only in the cycle after the strobe, zero elsewhere
  always_ff @(posedge I_CLK) begin
    if (I_RST || !I_RD) begin
      O_RDATA <= 32'h0;
    end else if (I_ADDR < A_FLD_END) begin
      O_RDATA <= I_ADDR[0] ? fld[wsel][63:32] : fld[wsel][31:0];
    end else begin
      case (I_ADDR)
        A_THR: O_RDATA <= thr;
        A_PNV: O_RDATA <= 32'(pnv);
        A_CTRL: O_RDATA <= 32'(ctrl);
        A_STAT: O_RDATA <= 32'(stat);
        A_MASK: O_RDATA <= 32'(mask);
        default: O_RDATA <= 32'h0;
      endcase
    end
  end

  // level interrupt from unmasked sticky bits
  always_ff @(posedge I_CLK) begin
    if (I_RST) O_IRQ <= 1'b0;
    else O_IRQ <= |(stat & mask);
  end

  // field values exported for the rest of the core
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_NOTIFY_VEC <= '0;
      O_VPAGE_ADDR <= 64'h0;
      O_DESC_ADDR <= 64'h0;
      O_EXEC_PTR <= 64'h0;
    end else begin
      O_NOTIFY_VEC <= pnv[VEC_W-1:0];
      O_VPAGE_ADDR <= fld[F_VPG];
      O_DESC_ADDR <= {fld[F_PDA][63:DESC_LSB], {DESC_LSB{1'b0}}};
      O_EXEC_PTR <= fld[F_EXE];
    end
  end

  // access-page hit compares page frames only
  always_ff @(posedge I_CLK) begin
    if (I_RST) O_ACC_HIT <= 1'b0;
    else O_ACC_HIT <= I_ACC_VALID && ctrl[CTL_ACC] &&
      I_ACC_ADDR[63:PAGE_LSB] == fld[F_ACC][63:PAGE_LSB];
  end

  // priority drop check; with virtual delivery on, the exit is not taken here
  assign next_tpr_exit = I_TPR_WR && ctrl[CTL_TPRSH] && !ctrl[CTL_VID] &&
    I_TPR_VALUE[VEC_W-1:THR_LSB_W] < thr[THR_LSB_W-1:0];
  always_ff @(posedge I_CLK) begin
    if (I_RST) O_TPR_EXIT <= 1'b0;
    else O_TPR_EXIT <= next_tpr_exit;
  end

  // vector's upper two bits pick the field, lower six the bit
  assign eoi_sel = F_EOI0 + {2'b00, I_EOI_VEC[7:6]};
  assign next_eoi_exit = I_EOI_WR && fld[eoi_sel][I_EOI_VEC[5:0]];
  always_ff @(posedge I_CLK) begin
    if (I_RST) O_EOI_EXIT <= 1'b0;
    else O_EOI_EXIT <= next_eoi_exit;
  end

  // entry check on the virtual page frame alignment
  assign next_entry_fail = I_ENTRY && ctrl[CTL_TPRSH] &&
    fld[F_VPG][PAGE_LSB-1:0] != '0;
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_ENTRY_DONE <= 1'b0;
      O_ENTRY_FAIL <= 1'b0;
    end else begin
      O_ENTRY_DONE <= I_ENTRY;
      O_ENTRY_FAIL <= next_entry_fail;
    end
  end

  // model-register range decode
  assign in_low = I_MSR_REQ.index <= LOW_HI;
  assign in_high = I_MSR_REQ.index >= HIGH_LO && I_MSR_REQ.index <= HIGH_HI;

  // virtual-page use flag for the x2-mode register window
  always_ff @(posedge I_CLK) begin
    if (I_RST) O_MSR_VPAGE <= 1'b0;
    else O_MSR_VPAGE <= I_MSR_VALID && ms == MS_IDLE && ctrl[CTL_X2] &&
      I_MSR_REQ.index >= X2_LO && I_MSR_REQ.index <= X2_HI;
  end

  // bitmap lookup: one byte fetched per in-range request with the bitmap on; new requests are
  // ignored while a fetch is outstanding, so the source must watch busy
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ms <= MS_IDLE;
      bit_pos <= 3'h0;
      O_MSR_BUSY <= 1'b0;
      O_MSR_DONE <= 1'b0;
      O_MSR_EXIT <= 1'b0;
      O_FETCH_REQ <= 1'b0;
      O_FETCH_ADDR <= 64'h0;
    end else begin
      O_MSR_DONE <= 1'b0;
      O_MSR_EXIT <= 1'b0;
      O_FETCH_REQ <= 1'b0;
      case (ms)
        MS_IDLE: begin
          if (I_MSR_VALID) begin
            if (!ctrl[CTL_MBM]) begin
              O_MSR_DONE <= 1'b1;
              O_MSR_EXIT <= 1'b1;
            end else if (!in_low && !in_high) begin
              O_MSR_DONE <= 1'b1;
              O_MSR_EXIT <= 1'b1;
            end else begin
              // base assumed 4-KByte aligned, so the sum never carries
              O_FETCH_ADDR <= fld[F_MBM] + (I_MSR_REQ.wr ? OFS_WR_LOW : 64'h0) +
                (in_high ? OFS_RD_HIGH : 64'h0) +
                64'(I_MSR_REQ.index[IDX_BITS-1:3]);
              bit_pos <= I_MSR_REQ.index[2:0];
              O_FETCH_REQ <= 1'b1;
              O_MSR_BUSY <= 1'b1;
              ms <= MS_FETCH;
            end
          end
        end
        MS_FETCH: begin
          if (I_FETCH_VALID) begin
            O_MSR_DONE <= 1'b1;
            O_MSR_EXIT <= I_FETCH_DATA[bit_pos];
            O_MSR_BUSY <= 1'b0;
            ms <= MS_IDLE;
          end
        end
        default: begin
          O_MSR_BUSY <= 1'b0;
          ms <= MS_IDLE;
        end
      endcase
    end
  end

  // events that feed the sticky status bits
  always_comb begin
    ev = '0;
    ev[EV_TPR] = next_tpr_exit;
    ev[EV_EOI] = next_eoi_exit;
    ev[EV_MSR] = O_MSR_DONE && O_MSR_EXIT;
    ev[EV_ENTRY] = next_entry_fail;
  end

  default clocking dc @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  eoi_exit_bit_a: assert property (
    I_EOI_WR |=> O_EOI_EXIT == $past(fld[eoi_sel][I_EOI_VEC[5:0]]))
    else $error("eoi exit does not follow vector bit");

  tpr_floor_a: assert property (
    I_TPR_WR && ctrl[CTL_TPRSH] && !ctrl[CTL_VID] &&
    I_TPR_VALUE[7:4] >= thr[3:0] |=> !O_TPR_EXIT)
    else $error("priority exit above threshold");

  tpr_vid_a: assert property (
    ctrl[CTL_VID] |=> !O_TPR_EXIT)
    else $error("priority exit with virtual delivery on");

  msr_nouse_a: assert property (
    I_MSR_VALID && ms == MS_IDLE && !ctrl[CTL_MBM] |=> O_MSR_DONE && !O_FETCH_REQ)
    else $error("bitmap consulted while unused");

  msr_range_a: assert property (
    I_MSR_VALID && ms == MS_IDLE && ctrl[CTL_MBM] && !in_low && !in_high
    |=> O_MSR_DONE && O_MSR_EXIT)
    else $error("out-of-range index did not exit");

  fetch_window_a: assert property (
    O_FETCH_REQ |-> O_FETCH_ADDR - fld[F_MBM] < OFS_REGION)
    else $error("fetch address outside bitmap region");

  // a new request may follow in the done cycle, so only the answer itself is checked
  fetch_done_a: assert property (
    ms == MS_FETCH && I_FETCH_VALID |=> O_MSR_DONE && !O_MSR_BUSY && ms == MS_IDLE)
    else $error("fetch return not answered");

  x2_page_a: assert property (
    O_MSR_VPAGE |-> $past(ctrl[CTL_X2]) && $past(I_MSR_REQ.index[31:8]) == 24'h8)
    else $error("virtual page flag outside window");

  entry_align_a: assert property (
    I_ENTRY && ctrl[CTL_TPRSH] && fld[F_VPG][11:0] != 12'h0
    |=> O_ENTRY_DONE && O_ENTRY_FAIL)
    else $error("misaligned page passed entry");

  stat_sticky_a: assert property (
    $rose(stat[EV_MSR]) |=> stat[EV_MSR] || $past(I_WR && I_ADDR == A_STAT))
    else $error("status bit lost without clear");

  acc_hit_gate_a: assert property (
    O_ACC_HIT |-> $past(I_ACC_VALID) && $past(ctrl[CTL_ACC]))
    else $error("access hit without request or control");

  tpr_below_a: assert property (
    I_TPR_WR && ctrl[CTL_TPRSH] && !ctrl[CTL_VID] &&
    I_TPR_VALUE[VEC_W-1:THR_LSB_W] < thr[THR_LSB_W-1:0] |=> O_TPR_EXIT)
    else $error("priority drop below threshold did not exit");

  eoi_idle_a: assert property (
    !I_EOI_WR |=> !O_EOI_EXIT)
    else $error("eoi exit without eoi write");

  msr_hold_a: assert property (
    ms == MS_FETCH && !I_FETCH_VALID |=> O_MSR_BUSY && !O_MSR_DONE)
    else $error("lookup ended before bitmap byte returned");

  fetch_start_a: assert property (
    I_MSR_VALID && ms == MS_IDLE && ctrl[CTL_MBM] && (in_low || in_high)
    |=> O_FETCH_REQ && O_MSR_BUSY && !O_MSR_DONE)
    else $error("in-range index did not start a bitmap fetch");

  x2_hit_a: assert property (
    I_MSR_VALID && ms == MS_IDLE && ctrl[CTL_X2] &&
    I_MSR_REQ.index >= X2_LO && I_MSR_REQ.index <= X2_HI |=> O_MSR_VPAGE)
    else $error("virtual page flag missing inside window");

  entry_pass_a: assert property (
    I_ENTRY && (!ctrl[CTL_TPRSH] || fld[F_VPG][PAGE_LSB-1:0] == '0)
    |=> O_ENTRY_DONE && !O_ENTRY_FAIL)
    else $error("aligned or unchecked entry failed");
endmodule : vicx_core

// [vicx_pkg.sv]
// vicx_pkg: field map, control bits, event bits and types for the
// interrupt-virtualization and model-register exit decision block.
// assumes a 32-bit word register port; 64-bit fields span two words.
package vicx_pkg;
  // register port word addresses; 64-bit field f sits at 2f (low) and 2f+1 (high)
  localparam int VICX_AW = 5;
  localparam int VICX_NUM_FLD = 9;
  localparam logic [3:0] F_ACC = 4'h0;
  localparam logic [3:0] F_VPG = 4'h1;
  localparam logic [3:0] F_EOI0 = 4'h2;
  localparam logic [3:0] F_PDA = 4'h6;
  localparam logic [3:0] F_MBM = 4'h7;
  localparam logic [3:0] F_EXE = 4'h8;
  localparam logic [4:0] A_FLD_END = 5'h12;
  localparam logic [4:0] A_THR = 5'h12;
  localparam logic [4:0] A_PNV = 5'h13;
  localparam logic [4:0] A_CTRL = 5'h14;
  localparam logic [4:0] A_STAT = 5'h15;
  localparam logic [4:0] A_MASK = 5'h16;
  // control register bits
  localparam int CTL_ACC = 0;
  localparam int CTL_X2 = 1;
  localparam int CTL_TPRSH = 2;
  localparam int CTL_VID = 3;
  localparam int CTL_MBM = 4;
  localparam int CTL_W = 5;
  // status / mask bits
  localparam int EV_TPR = 0;
  localparam int EV_EOI = 1;
  localparam int EV_MSR = 2;
  localparam int EV_ENTRY = 3;
  localparam int EV_W = 4;
  // field widths and alignment
  localparam int THR_W = 32;
  localparam int THR_LSB_W = 4;
  localparam int PNV_W = 16;
  localparam int VEC_W = 8;
  localparam int PAGE_LSB = 12;
  localparam int DESC_LSB = 6;
  localparam int IDX_BITS = 13;
  // model-register index ranges
  localparam logic [31:0] X2_LO = 32'h0000_0800;
  localparam logic [31:0] X2_HI = 32'h0000_08ff;
  localparam logic [31:0] LOW_LO = 32'h0000_0000;
  localparam logic [31:0] LOW_HI = 32'h0000_1fff;
  localparam logic [31:0] HIGH_LO = 32'hc000_0000;
  localparam logic [31:0] HIGH_HI = 32'hc000_1fff;
  // bitmap quarter offsets within the 4-KByte region
  localparam logic [63:0] OFS_RD_HIGH = 64'h0000_0000_0000_0400;
  localparam logic [63:0] OFS_WR_LOW = 64'h0000_0000_0000_0800;
  localparam logic [63:0] OFS_REGION = 64'h0000_0000_0000_1000;

  typedef struct packed {
    logic wr;
    logic [31:0] index;
  } vicx_msr_req_t;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_FETCH = 2'b01
  } vicx_msr_st_t;
endpackage : vicx_pkg
